// ### hw/urad_decode.sv
// Module: universal register access decode and check, two slots
//
// Behaviour
// - Every register in an assigned group reachable by its memory address
// - Single, dual and quad register accesses allowed
// - Sequencer, DMA status, bus, test groups single-only
// - Multiprocessor self-read raises illegal access
// - Multiprocessor self-write, broadcast too, completes
// - Dual even-aligned, quad aligned to four
// - Normal access pairs size with word width
// - Broadcast-mode writes and remote accesses fault; merged accesses supported
// - Broadcast read faults on local access; broadcast write to all
// - Sixty-four groups of thirty-two registers
// - Low groups all transfers, high groups moves on local access
// - Core group assignment decoded
// - System-side group assignment decoded
// - Group from address bits 16 and 9..5
// - Reserved bits written zero, read ignored
// - Load, store and move copy directions
// - Up to two accesses per instruction line
// - Registers reached only through multiprocessor space on local access
// - Bits 30..26 choose broadcast or processor
module urad_decode #(
	parameter int SLOTS = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Own identity
	input wire logic [2:0] processor_identifier_field,
	// Access slots from core or cluster bus
	input wire logic [SLOTS-1:0] acc_valid,
	input wire logic [SLOTS-1:0] acc_write,
	input wire logic [SLOTS-1:0] acc_remote,
	input wire logic [SLOTS*2-1:0] acc_op,
	input wire logic [SLOTS*2-1:0] acc_size,
	input wire logic [SLOTS*2-1:0] acc_mode,
	input wire logic [SLOTS*32-1:0] acc_addr,
	// Decode results
	output logic [SLOTS-1:0] dec_hit,
	output logic [SLOTS-1:0] dec_ok,
	output logic [SLOTS-1:0] dec_fault,
	output logic [SLOTS*6-1:0] dec_group,
	output logic [SLOTS*5-1:0] dec_reg,
	output logic [SLOTS*8-1:0] dec_word_bits,
	output logic [SLOTS-1:0] dec_all_procs,
	output logic [SLOTS*urad_pkg::FLT_W-1:0] dec_cause,
	output logic illegal_access
);

	// Elaboration check of slot count
	if (SLOTS < 1 || SLOTS > 2) begin : g_slots_check
		$error("SLOTS must be 1 or 2");
	end

	// ====================================================================
	// Helper functions
	function automatic logic [5:0] grp_of(input logic [31:0] a);
		grp_of = {a[urad_pkg::GRP_HI_BIT],
			a[urad_pkg::GRP_LO_MSB:urad_pkg::GRP_LO_LSB]};
	endfunction

	function automatic logic in_rng(input logic [5:0] g,
		input logic [5:0] lo, input logic [5:0] hi);
		in_rng = (g >= lo) && (g <= hi);
	endfunction

	function automatic logic assigned(input logic [5:0] g);
		assigned = in_rng(g, urad_pkg::GRP_CB_LO, urad_pkg::GRP_CB_HI) ||
			in_rng(g, urad_pkg::GRP_IALU_LO, urad_pkg::GRP_IALU_HI) ||
			g == urad_pkg::GRP_DBG_A || g == urad_pkg::GRP_DBG_B ||
			g == urad_pkg::GRP_SEQ ||
			in_rng(g, urad_pkg::GRP_MEM_LO, urad_pkg::GRP_MEM_HI);
		assigned = assigned ||
			in_rng(g, urad_pkg::GRP_DMA_LO, urad_pkg::GRP_DMA_CS) ||
			g == urad_pkg::GRP_EBI ||
			in_rng(g, urad_pkg::GRP_LINK_LO, urad_pkg::GRP_LINK_HI) ||
			in_rng(g, urad_pkg::GRP_INT_LO, urad_pkg::GRP_INT_HI) ||
			g == urad_pkg::GRP_TEST || g == urad_pkg::GRP_ADMA;
	endfunction

	function automatic logic single_only(input logic [5:0] g);
		single_only = g == urad_pkg::GRP_SEQ || g == urad_pkg::GRP_DMA_CS ||
			g == urad_pkg::GRP_EBI || g == urad_pkg::GRP_TEST;
	endfunction

	// ====================================================================
	// Per-slot state
	urad_pkg::urad_state_t state [SLOTS];
	urad_pkg::urad_state_t next_state [SLOTS];
	logic [SLOTS-1:0] next_hit;
	logic [SLOTS-1:0] next_ok;
	logic [SLOTS-1:0] next_fault;
	logic [SLOTS*6-1:0] next_group;
	logic [SLOTS*5-1:0] next_reg;
	logic [SLOTS*8-1:0] next_word_bits;
	logic [SLOTS-1:0] next_all_procs;
	logic [SLOTS*urad_pkg::FLT_W-1:0] next_cause;
	logic next_illegal;

	always_comb begin
		logic [31:0] a;
		logic [4:0] tgt;
		logic [5:0] g;
		logic [4:0] r;
		logic [1:0] sz;
		logic [1:0] op;
		logic [1:0] md;
		logic mp;
		logic self;
		logic bc;
		logic [urad_pkg::FLT_W-1:0] c;
		a = '0;
		tgt = '0;
		g = '0;
		r = '0;
		sz = '0;
		op = '0;
		md = '0;
		mp = 1'b0;
		self = 1'b0;
		bc = 1'b0;
		c = '0;
		next_hit = '0;
		next_ok = '0;
		next_fault = '0;
		next_group = '0;
		next_reg = '0;
		next_word_bits = '0;
		next_all_procs = '0;
		next_cause = '0;
		next_illegal = 1'b0;
		for (int i = 0; i < SLOTS; i++) begin
			next_state[i] = urad_pkg::URAD_ST_IDLE;
			a = acc_addr[i*32 +: 32];
			sz = acc_size[i*2 +: 2];
			op = acc_op[i*2 +: 2];
			md = acc_mode[i*2 +: 2];
			tgt = a[urad_pkg::TGT_MSB:urad_pkg::TGT_LSB];
			g = grp_of(a);
			r = a[urad_pkg::REG_MSB:0];
			// Multiprocessor target decode
			bc = tgt == urad_pkg::TGT_BCAST;
			self = (tgt >= urad_pkg::TGT_ID_FIRST) &&
				(tgt <= urad_pkg::TGT_ID_LAST) &&
				((tgt - urad_pkg::TGT_ID_FIRST) ==
				{2'b00, processor_identifier_field});
			// Remote masters hit on any target code; local only via own ID or broadcast
			mp = acc_remote[i] ? 1'b1 : (self || bc);
			c = '0;
			if (acc_valid[i] && !a[urad_pkg::HOST_BIT] && mp &&
				assigned(g)) begin
				next_hit[i] = 1'b1;
				c[urad_pkg::FLT_SELF_READ] = !acc_remote[i] && !acc_write[i]
					&& (self || bc);
				c[urad_pkg::FLT_ALIGN] =
					(sz == urad_pkg::URAD_SZ_DUAL && r[0]) ||
					(sz == urad_pkg::URAD_SZ_QUAD && r[1:0] != 2'b00) ||
					sz == 2'b11;
				c[urad_pkg::FLT_SINGLE_ONLY] = single_only(g) &&
					sz != urad_pkg::URAD_SZ_SINGLE;
				c[urad_pkg::FLT_CLASS] = g[5] && !acc_remote[i] &&
					op != urad_pkg::URAD_OP_MOVE;
				if (md == urad_pkg::URAD_MODE_BCAST &&
					(acc_write[i] || acc_remote[i])) begin
					c[urad_pkg::FLT_CLASS] = 1'b1;
				end
				next_cause[i*urad_pkg::FLT_W +: urad_pkg::FLT_W] = c;
				next_group[i*6 +: 6] = g;
				next_reg[i*5 +: 5] = r;
				next_all_procs[i] = bc && acc_write[i];
				case (sz)
					urad_pkg::URAD_SZ_SINGLE: begin
						next_word_bits[i*8 +: 8] = urad_pkg::WORD_BITS_SINGLE;
					end
					urad_pkg::URAD_SZ_DUAL: begin
						next_word_bits[i*8 +: 8] = urad_pkg::WORD_BITS_DUAL;
					end
					default: begin
						next_word_bits[i*8 +: 8] = urad_pkg::WORD_BITS_QUAD;
					end
				endcase
				if (c != '0) begin
					next_fault[i] = 1'b1;
					next_state[i] = urad_pkg::URAD_ST_FAULT;
				end else begin
					next_ok[i] = 1'b1;
					next_state[i] = urad_pkg::URAD_ST_DONE;
				end
			end
		end
		next_illegal = |next_fault;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < SLOTS; i++) begin
				state[i] <= urad_pkg::URAD_ST_IDLE;
			end
			dec_hit <= '0;
			dec_ok <= '0;
			dec_fault <= '0;
			dec_group <= '0;
			dec_reg <= '0;
			dec_word_bits <= '0;
			dec_all_procs <= '0;
			dec_cause <= '0;
			illegal_access <= 1'b0;
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				state[i] <= next_state[i];
			end
			dec_hit <= next_hit;
			dec_ok <= next_ok;
			dec_fault <= next_fault;
			dec_group <= next_group;
			dec_reg <= next_reg;
			dec_word_bits <= next_word_bits;
			dec_all_procs <= next_all_procs;
			dec_cause <= next_cause;
			illegal_access <= next_illegal;
		end
	end

endmodule // urad_decode

// ### inc/urad_pkg.sv
// Package: constants and types for universal register access decode
package urad_pkg;

	// ====================================================================
	// Address fields
	localparam int ADDR_W = 32;
	localparam int GRP_HI_BIT = 16;
	localparam int GRP_LO_MSB = 9;
	localparam int GRP_LO_LSB = 5;
	localparam int REG_MSB = 4;
	localparam int TGT_MSB = 30;
	localparam int TGT_LSB = 26;
	localparam int HOST_BIT = 31;
	localparam int NUM_GROUPS = 64;
	localparam int REGS_PER_GROUP = 32;

	// ====================================================================
	// Target select codes
	localparam logic [4:0] TGT_INTERNAL = 5'h00;
	localparam logic [4:0] TGT_BCAST = 5'h03;
	localparam logic [4:0] TGT_ID_FIRST = 5'h04;
	localparam logic [4:0] TGT_ID_LAST = 5'h0b;

	// ====================================================================
	// Group numbers
	localparam logic [5:0] GRP_CB_LO = 6'h00;
	localparam logic [5:0] GRP_CB_HI = 6'h09;
	localparam logic [5:0] GRP_DBG_A = 6'h0a;
	localparam logic [5:0] GRP_IALU_LO = 6'h0c;
	localparam logic [5:0] GRP_IALU_HI = 6'h0f;
	localparam logic [5:0] GRP_SEQ = 6'h1a;
	localparam logic [5:0] GRP_DBG_B = 6'h1b;
	localparam logic [5:0] GRP_MEM_LO = 6'h1e;
	localparam logic [5:0] GRP_MEM_HI = 6'h1f;
	localparam logic [5:0] GRP_DMA_LO = 6'h20;
	localparam logic [5:0] GRP_DMA_CS = 6'h23;
	localparam logic [5:0] GRP_EBI = 6'h24;
	localparam logic [5:0] GRP_LINK_LO = 6'h25;
	localparam logic [5:0] GRP_LINK_HI = 6'h27;
	localparam logic [5:0] GRP_INT_LO = 6'h38;
	localparam logic [5:0] GRP_INT_HI = 6'h3a;
	localparam logic [5:0] GRP_TEST = 6'h3d;
	localparam logic [5:0] GRP_ADMA = 6'h3f;

	// ====================================================================
	// Encodings
	typedef enum logic [1:0] {
		URAD_SZ_SINGLE = 2'b00,
		URAD_SZ_DUAL = 2'b01,
		URAD_SZ_QUAD = 2'b10
	} urad_size_t;

	typedef enum logic [1:0] {
		URAD_OP_LOAD = 2'b00,
		URAD_OP_STORE = 2'b01,
		URAD_OP_MOVE = 2'b10,
		URAD_OP_IMM = 2'b11
	} urad_op_t;

	typedef enum logic [1:0] {
		URAD_MODE_NORMAL = 2'b00,
		URAD_MODE_BCAST = 2'b01,
		URAD_MODE_MERGED = 2'b10
	} urad_mode_t;

	typedef enum logic [1:0] {
		URAD_ST_IDLE = 2'b00,
		URAD_ST_DONE = 2'b01,
		URAD_ST_FAULT = 2'b10
	} urad_state_t;

	localparam logic [7:0] WORD_BITS_SINGLE = 8'h20;
	localparam logic [7:0] WORD_BITS_DUAL = 8'h40;
	localparam logic [7:0] WORD_BITS_QUAD = 8'h80;

	// Fault causes
	localparam int FLT_W = 4;
	localparam int FLT_SELF_READ = 0;
	localparam int FLT_ALIGN = 1;
	localparam int FLT_SINGLE_ONLY = 2;
	localparam int FLT_CLASS = 3;

endpackage : urad_pkg

// ### testbench/urad_master_model.sv
// Remote master model: forms cluster bus register addresses
module urad_master_model (
	// Target and register
	input wire logic host,
	input wire logic [4:0] tgt,
	input wire logic [5:0] grp,
	input wire logic [4:0] rg,
	// Address to device
	output logic [31:0] addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// Processor offset plus group address
	// Unused address bits always zero
	assign addr = {host, tgt, 9'h000, grp[5], 6'h00, grp[4:0], rg};
endmodule // urad_master_model

// ### testbench/urad_decode_assertions.sv
// Checker: concurrent assertions on the decode ports
module urad_decode_assertions #(
	parameter int SLOTS = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Decode inputs
	input wire logic [2:0] processor_identifier_field,
	input wire logic [SLOTS-1:0] acc_valid,
	input wire logic [SLOTS-1:0] acc_write,
	input wire logic [SLOTS-1:0] acc_remote,
	input wire logic [SLOTS*2-1:0] acc_op,
	input wire logic [SLOTS*2-1:0] acc_size,
	input wire logic [SLOTS*2-1:0] acc_mode,
	input wire logic [SLOTS*32-1:0] acc_addr,
	// Decode outputs
	input wire logic [SLOTS-1:0] dec_hit,
	input wire logic [SLOTS-1:0] dec_ok,
	input wire logic [SLOTS-1:0] dec_fault,
	input wire logic [SLOTS*6-1:0] dec_group,
	input wire logic [SLOTS*5-1:0] dec_reg,
	input wire logic [SLOTS*8-1:0] dec_word_bits,
	input wire logic [SLOTS-1:0] dec_all_procs,
	input wire logic [SLOTS*urad_pkg::FLT_W-1:0] dec_cause,
	input wire logic illegal_access
);
	timeunit 1ns;
	timeprecision 1ns;
	logic own;
	logic [5:0] grp;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	assign own = acc_valid[0] && !acc_remote[0] && !acc_addr[31] &&
		acc_addr[30:26] == 5'h04 + {2'h0, processor_identifier_field};
	assign grp = {acc_addr[16], acc_addr[9:5]};
	AST_ILLEGAL: assert property (illegal_access == |dec_fault)
		else $error("illegal flag differs from faults");
	AST_SELF_READ: assert property (own && !acc_write[0] |=> !dec_ok[0])
		else $error("self read completed");
	AST_SELF_WRITE: assert property (own && acc_write[0] &&
		acc_size[1:0] == 2'h0 && acc_mode[1:0] == 2'h0 && grp == 6'h1e
		|=> dec_ok[0]) else $error("self write refused");
	AST_ALIGN: assert property (acc_valid[0] && acc_size[1:0] == 2'h2 &&
		acc_addr[1:0] != 2'h0 |=> !dec_ok[0]) else $error("misaligned quad ok");
	AST_SGL_ONLY: assert property (acc_valid[0] && acc_size[1:0] != 2'h0 &&
		grp == 6'h1a |=> !dec_ok[0]) else $error("wide access to single group");
	AST_GROUP: assert property (dec_hit[0] |->
		dec_group[5:0] == {$past(acc_addr[16]), $past(acc_addr[9:5])})
		else $error("group field wrong");
	AST_REG: assert property (dec_hit[0] |->
		dec_reg[4:0] == $past(acc_addr[4:0])) else $error("register wrong");
	AST_WORD: assert property (dec_hit[0] && $past(acc_size[1:0]) == 2'h1
		|-> dec_word_bits[7:0] == 8'h40) else $error("dual word width wrong");
	AST_NO_HIT: assert property (acc_valid[0] && (acc_addr[31] ||
		!acc_remote[0] && acc_addr[30:26] == 5'h00) |=> !dec_hit[0])
		else $error("register hit outside multiprocessor space");
	AST_BCAST: assert property (dec_all_procs[0] |-> $past(acc_write[0]) &&
		$past(acc_addr[30:26]) == 5'h03) else $error("broadcast flag wrong");
	AST_SLOT1: assert property (dec_hit[1] |->
		dec_group[11:6] == {$past(acc_addr[48]), $past(acc_addr[41:37])})
		else $error("second slot group wrong");
endmodule // urad_decode_assertions

bind urad_decode urad_decode_assertions #(.SLOTS(SLOTS)) i_urad_decode_assertions (
	.ref_clk(ref_clk), .rstn(rstn),
	.processor_identifier_field(processor_identifier_field),
	.acc_valid(acc_valid), .acc_write(acc_write), .acc_remote(acc_remote),
	.acc_op(acc_op), .acc_size(acc_size), .acc_mode(acc_mode),
	.acc_addr(acc_addr), .dec_hit(dec_hit), .dec_ok(dec_ok),
	.dec_fault(dec_fault), .dec_group(dec_group), .dec_reg(dec_reg),
	.dec_word_bits(dec_word_bits), .dec_all_procs(dec_all_procs),
	.dec_cause(dec_cause), .illegal_access(illegal_access));

// ### testbench/universal_register_access_decode_tb.sv
// Testbench: table of accesses, then reset and slot cases
module universal_register_access_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0] w, rm, op, sz, md;
		logic [7:0] tgt, grp, rg;
		logic [3:0] hit, ok, all, cause;
		logic [7:0] bits;
	} urad_row_t;
	logic ref_clk = 1'h0;
	logic rstn = 1'h0;
	logic host = 1'h0;
	logic [1:0] acc_valid = 2'h0, acc_write = 2'h0, acc_remote = 2'h0;
	logic [3:0] acc_op = 4'h0, acc_size = 4'h0, acc_mode = 4'h0;
	logic [4:0] tgt = 5'h00, rg = 5'h00;
	logic [5:0] grp = 6'h00;
	logic [31:0] m_addr;
	logic [1:0] dec_hit, dec_ok, dec_fault, dec_all_procs;
	logic [11:0] dec_group;
	logic [9:0] dec_reg;
	logic [15:0] dec_word_bits;
	logic [7:0] dec_cause;
	logic illegal_access;
	logic [2:0] pid = 3'h2;
	int err_count = 0;
	int num_checks = 0;
	// w rm op sz md tgt grp rg hit ok all cause bits
	urad_row_t rows [20] = '{
		68'h1_0_1_0_0_06_1e_00_1_1_0_0_20,
		68'h0_0_0_0_0_06_1e_00_1_0_0_1_20,
		68'h1_0_1_1_0_06_00_02_1_1_0_0_40,
		68'h1_0_1_1_0_06_00_03_1_0_0_2_40,
		68'h0_1_0_2_0_06_0c_04_1_1_0_0_80,
		68'h0_1_0_2_0_06_0c_02_1_0_0_2_80,
		68'h1_0_1_1_0_06_1a_00_1_0_0_4_40,
		68'h0_1_0_1_0_06_23_00_1_0_0_4_40,
		68'h0_1_0_2_0_06_3d_00_1_0_0_4_80,
		68'h0_1_0_0_0_06_24_00_1_1_0_0_20,
		68'h1_0_1_0_0_06_24_00_1_0_0_8_20,
		68'h1_0_2_0_0_06_38_00_1_1_0_0_20,
		68'h1_0_1_0_0_00_1e_00_0_0_0_0_00,
		68'h1_0_1_0_0_06_10_00_0_0_0_0_00,
		68'h1_0_1_0_0_03_0a_00_1_1_1_0_20,
		68'h1_0_1_0_1_06_1e_00_1_0_0_8_20,
		68'h1_0_1_1_2_06_02_00_1_1_0_0_40,
		68'h0_1_0_1_0_05_0e_02_1_1_0_0_40,
		68'h1_1_1_3_0_06_1e_00_1_0_0_2_80,
		68'h1_0_3_0_0_06_20_00_1_0_0_8_20
	};
	urad_master_model i_urad_master_model (.host(host), .tgt(tgt),
		.grp(grp), .rg(rg), .addr(m_addr));
	urad_decode i_urad_decode (.ref_clk(ref_clk), .rstn(rstn),
		.processor_identifier_field(pid), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_remote(acc_remote), .acc_op(acc_op),
		.acc_size(acc_size), .acc_mode(acc_mode), .acc_addr({2{m_addr}}),
		.dec_hit(dec_hit), .dec_ok(dec_ok), .dec_fault(dec_fault),
		.dec_group(dec_group), .dec_reg(dec_reg),
		.dec_word_bits(dec_word_bits), .dec_all_procs(dec_all_procs),
		.dec_cause(dec_cause), .illegal_access(illegal_access));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string n, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apply(input urad_row_t r, input logic [1:0] v = 2'h3);
		acc_valid = v;
		acc_write = {2{r.w[0]}};
		acc_remote = {2{r.rm[0]}};
		acc_op = {2{r.op[1:0]}};
		acc_size = {2{r.sz[1:0]}};
		acc_mode = {2{r.md[1:0]}};
		tgt = r.tgt[4:0];
		grp = r.grp[5:0];
		rg = r.rg[4:0];
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic expect_row(input urad_row_t r);
		for (int s = 0; s < 2; s++) begin
			chk("hit", dec_hit[s], r.hit);
			chk("ok", dec_ok[s], r.ok);
			chk("fault", dec_fault[s], r.hit & ~r.ok);
			chk("group", dec_group[s*6+:6], r.hit[0] ? r.grp : 8'h00);
			chk("reg", dec_reg[s*5+:5], r.hit[0] ? r.rg : 8'h00);
			chk("bits", dec_word_bits[s*8+:8], r.bits);
			chk("all", dec_all_procs[s], r.all);
			chk("cause", dec_cause[s*4+:4], r.cause);
		end
		chk("illegal", illegal_access, r.hit & ~r.ok);
	endtask
	initial begin
		apply(rows[0]);
		repeat (4) @(posedge ref_clk);
		#1;
		chk("reset hit", dec_hit, 8'h00);
		rstn = 1'h1;
		foreach (rows[i]) begin
			apply(rows[i]);
			step();
			expect_row(rows[i]);
		end
		$display("test table done");
		host = 1'h1;
		apply(rows[0]);
		step();
		chk("host hit", dec_hit, 8'h00);
		$display("test host done");
		host = 1'h0;
		apply(rows[1], 2'h2);
		step();
		chk("slot fault", dec_fault, 8'h02);
		chk("slot illegal", illegal_access, 8'h01);
		$display("test slot done");
		pid = 3'h4;
		apply(68'h0_0_0_0_0_08_1e_00_1_0_0_1_20);
		step();
		expect_row(68'h0_0_0_0_0_08_1e_00_1_0_0_1_20);
		apply(rows[1]);
		step();
		chk("other id hit", dec_hit, 8'h00);
		pid = 3'h2;
		$display("test id done");
		rstn = 1'h0;
		#1;
		chk("reset illegal", illegal_access, 8'h00);
		step();
		rstn = 1'h1;
		apply(rows[1]);
		step();
		expect_row(rows[1]);
		$display("test reset done");
		test_done();
	end
endmodule // universal_register_access_decode_tb
